//--- asq_pkg.sv
/*
 conversion sequencer package: register offsets, control field positions,
 reset values and cycle counts shared by the sequencer and its helpers.
 assumes an 8-bit special function register bus with 8-bit addresses.
*/
package asq_pkg;

    // register offsets
    localparam logic [7:0] OFS_CLOCK_DIVIDER = 8'h95;
    localparam logic [7:0] OFS_CONTROL       = 8'ha2;
    localparam logic [7:0] OFS_RATE_LOW      = 8'ha3;
    localparam logic [7:0] OFS_RATE_MID      = 8'ha4;
    localparam logic [7:0] OFS_RATE_HIGH     = 8'ha5;
    localparam logic [7:0] OFS_RESULT0_LOW   = 8'ha6;
    localparam logic [7:0] OFS_RESULT0_HIGH  = 8'ha7;
    localparam logic [7:0] OFS_RESULT1_LOW   = 8'ha9;
    localparam logic [7:0] OFS_RESULT1_HIGH  = 8'haa;
    localparam logic [7:0] OFS_RESULT2_LOW   = 8'hab;
    localparam logic [7:0] OFS_RESULT2_HIGH  = 8'hac;
    localparam logic [7:0] OFS_RESULT3_LOW   = 8'had;
    localparam logic [7:0] OFS_RESULT3_HIGH  = 8'hae;
    localparam logic [7:0] OFS_INPUT_SEL     = 8'hb6;
    localparam logic [7:0] OFS_GAIN_TRIM     = 8'hbc;

    // control register bit positions
    localparam int CTL_IRQ_CLEAR   = 7;
    localparam int CTL_REFCAP      = 6;
    localparam int CTL_KEEP_ONE    = 5;
    localparam int CTL_IRQ_FLAG    = 4;
    localparam int CTL_IRQ_ENABLE  = 3;
    localparam int CTL_SINGLE_CHAN = 2;
    localparam int CTL_FREE_RUN    = 1;
    localparam int CTL_START       = 0;

    // input selection fields
    localparam int SEL_PICK_LSB   = 4;
    localparam int SEL_BANK_BIT   = 6;

    // reset values
    localparam logic [7:0] RST_CONTROL     = 8'h60;
    localparam logic [7:0] RST_DIVIDER     = 8'h00;
    localparam logic [7:0] RST_INPUT_SEL   = 8'h00;
    localparam logic [7:0] RST_RATE_BYTE   = 8'h00;
    localparam logic [7:0] RST_GAIN_TRIM   = 8'h00;

    // converter clock: one half period spans 2*(divider+1) system clocks
    localparam logic [9:0] CLK_HALF_MULT = 10'h002;
    // converter clock cycles per channel
    localparam logic [6:0] CONV_CYCLES   = 7'h6f;
    // channel code for the internal test point
    localparam logic [2:0] CHAN_TEST_POINT = 3'h7;

    typedef struct packed {
        logic [2:0]  channel;
        logic [11:0] data;
    } asq_result_t;

endpackage : asq_pkg

//--- asq_clk_div.sv
/*
 converter clock divider: divides the system clock by 4*(div+1).
 assumes the divider value is stable while a conversion runs.
*/
`timescale 1ns/1ps
module asq_clk_div
    import asq_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] i_div,
    output logic            o_conv_clk,
    output logic            o_rise
);
    logic [9:0] cnt_ff;
    logic [9:0] half_len;

    assign half_len = CLK_HALF_MULT * ({2'h0, i_div} + 10'h001);

    // [R14] divide by four times value plus one
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            cnt_ff     <= 10'h000;
            o_conv_clk <= 1'b0;
            o_rise     <= 1'b0;
        end
        else if (cnt_ff + 10'h001 >= half_len)
        begin
            cnt_ff     <= 10'h000;
            o_conv_clk <= ~o_conv_clk;
            o_rise     <= ~o_conv_clk;
        end
        else
        begin
            cnt_ff <= cnt_ff + 10'h001;
            o_rise <= 1'b0;
        end
    end
endmodule : asq_clk_div

//--- asq_rate_timer.sv
/*
 continuous-mode rate timer: pulses once every rate+1 system clocks.
 assumes the enable drops whenever free-running mode is left.
*/
`timescale 1ns/1ps
module asq_rate_timer
    import asq_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_en,
    input  wire logic [23:0] i_rate,
    output logic             o_tick
);
    logic [23:0] cnt_ff;

    // [R17] 24-bit rate time base
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b || !i_en)
        begin
            cnt_ff <= 24'h000000;
            o_tick <= 1'b0;
        end
        else if (cnt_ff >= i_rate)
        begin
            cnt_ff <= 24'h000000;
            o_tick <= 1'b1;
        end
        else
        begin
            cnt_ff <= cnt_ff + 24'h000001;
            o_tick <= 1'b0;
        end
    end
endmodule : asq_rate_timer

//--- asq_sequencer.sv
/*
 conversion sequencer: special function registers, channel sequencing,
 result storage and the conversion interrupt request.
 assumes a one-cycle write strobe and a combinationally answered read
 that is registered here; the analog core returns a 12-bit sample.
*/
// Functional notes
// [R01] one channel, lower four or upper four
// [R02] software enables input buffers before converting
// [R03] select field picks input or test point
// [R04] bit 6 picks upper or lower bank
// [R05] clear bit write clears pending interrupt
// [R06] software writes bits 6,5 as one
// [R07] flag readable, writing one raises it
// [R08] enable bit gates interrupt to processor
// [R09] software clears flag before enabling
// [R10] single mode stores into channel zero
// [R11] four mode stores per-channel results
// [R12] free-running starts timed by rate register
// [R13] start bit triggers one pass
// [R14] converter clock divides by 4(div+1)
// [R15] 111 converter clocks per channel
// [R16] software keeps converter clock in range
// [R17] 24-bit rate from three bytes
// [R18] four-channel pass rate quartered
// [R19] shared vector needs group and global enables
// [R20] software clears both flags after service
// [R21] software keeps test output powered down
// [R22] result low eight bits, high four
// [R23] start bit self-clears once pass begins
`timescale 1ns/1ps
module asq_sequencer
    import asq_pkg::*;
(
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST_B,
    input  wire logic [7:0]  I_SFR_ADDR,
    input  wire logic [7:0]  I_SFR_WDATA,
    input  wire logic        I_SFR_WR,
    input  wire logic        I_SFR_RD,
    input  wire logic [11:0] I_SAMPLE,
    input  wire logic        I_GROUP_IRQ_EN,
    input  wire logic        I_GLOBAL_IRQ_EN,
    output logic [7:0]       O_SFR_RDATA,
    output logic [2:0]       O_MUX_CHANNEL,
    output logic [3:0]       O_BUFFER_EN,
    output logic             O_CONV_CLK,
    output logic             O_CONV_START,
    output logic             O_BUSY,
    output logic             O_IRQ_REQ
);
    typedef enum logic [1:0] {ST_IDLE, ST_LAUNCH, ST_CONVERT, ST_STORE} asq_state_t;

    logic [7:0]  divider_ff;
    logic [7:0]  input_sel_ff;
    logic [7:0]  gain_trim_ff;
    logic [23:0] rate_ff;
    logic        refcap_ff;
    logic        keep_one_ff;
    logic        irq_flag_ff;
    logic        irq_en_ff;
    logic        single_ff;
    logic        free_run_ff;
    logic        start_ff;
    asq_state_t  state_ff;
    logic [1:0]  slot_ff;
    logic [6:0]  cycles_ff;
    logic        pending_ff;
    logic [11:0] result_ff [4];
    asq_result_t done;
    logic        conv_clk;
    logic        conv_rise;
    logic        rate_tick;
    logic        wr_ctl;
    logic        pass_done;
    logic [2:0]  nxt_channel;
    logic [7:0]  ctl_view;
    logic [7:0]  nxt_rdata;

    asq_clk_div u_clk_div (
        .i_clk      (I_CORE_CLK),
        .i_rst_b    (I_RST_B),
        .i_div      (divider_ff),
        .o_conv_clk (conv_clk),
        .o_rise     (conv_rise)
    );

    asq_rate_timer u_rate (
        .i_clk   (I_CORE_CLK),
        .i_rst_b (I_RST_B),
        .i_en    (free_run_ff),
        .i_rate  (rate_ff),
        .o_tick  (rate_tick)
    );

    assign wr_ctl = I_SFR_WR && (I_SFR_ADDR == OFS_CONTROL);

    // [R01] channel for the current slot
    always_comb
    begin
        if (single_ff)
            // [R03] single channel pick
            nxt_channel = input_sel_ff[SEL_PICK_LSB +: 3];
        else
            // [R04] bank bit selects four channels
            nxt_channel = {input_sel_ff[SEL_BANK_BIT], slot_ff};
    end

    // configuration registers
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
        begin
            divider_ff   <= RST_DIVIDER;
            input_sel_ff <= RST_INPUT_SEL;
            gain_trim_ff <= RST_GAIN_TRIM;
            rate_ff      <= {3{RST_RATE_BYTE}};
        end
        else if (I_SFR_WR)
        begin
            unique case (I_SFR_ADDR)
                OFS_CLOCK_DIVIDER: divider_ff   <= I_SFR_WDATA;
                OFS_INPUT_SEL:     input_sel_ff <= {1'b0, I_SFR_WDATA[6:0]};
                OFS_GAIN_TRIM:     gain_trim_ff <= {I_SFR_WDATA[7], 7'h00};
                // [R17] rate bytes low, mid, high
                OFS_RATE_LOW:      rate_ff[7:0]   <= I_SFR_WDATA;
                OFS_RATE_MID:      rate_ff[15:8]  <= I_SFR_WDATA;
                OFS_RATE_HIGH:     rate_ff[23:16] <= I_SFR_WDATA;
                default:           ;
            endcase
        end
    end

    // control mode bits
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
        begin
            refcap_ff   <= RST_CONTROL[CTL_REFCAP];
            keep_one_ff <= RST_CONTROL[CTL_KEEP_ONE];
            irq_en_ff   <= RST_CONTROL[CTL_IRQ_ENABLE];
            single_ff   <= RST_CONTROL[CTL_SINGLE_CHAN];
            free_run_ff <= RST_CONTROL[CTL_FREE_RUN];
        end
        else if (wr_ctl)
        begin
            refcap_ff   <= I_SFR_WDATA[CTL_REFCAP];
            keep_one_ff <= I_SFR_WDATA[CTL_KEEP_ONE];
            irq_en_ff   <= I_SFR_WDATA[CTL_IRQ_ENABLE];
            single_ff   <= I_SFR_WDATA[CTL_SINGLE_CHAN];
            free_run_ff <= I_SFR_WDATA[CTL_FREE_RUN];
        end
    end

    // start request
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
            start_ff <= 1'b0;
        else if (wr_ctl && I_SFR_WDATA[CTL_START])
            start_ff <= 1'b1;
        // [R23] start self-clears at pass launch
        else if (state_ff == ST_LAUNCH)
            start_ff <= 1'b0;
    end

    // [R12] free-running tick held until idle
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B || !free_run_ff)
            pending_ff <= 1'b0;
        else if (rate_tick)
            pending_ff <= 1'b1;
        else if (state_ff == ST_IDLE)
            pending_ff <= 1'b0;
    end

    assign pass_done = (state_ff == ST_STORE) && (single_ff || slot_ff == 2'h3);

    // sequencing state machine
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
        begin
            state_ff  <= ST_IDLE;
            slot_ff   <= 2'h0;
            cycles_ff <= 7'h00;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                begin
                    slot_ff <= 2'h0;
                    // [R13] one pass per start in trigger mode
                    if ((free_run_ff && pending_ff) || (!free_run_ff && start_ff))
                        state_ff <= ST_LAUNCH;
                end
                ST_LAUNCH:
                begin
                    cycles_ff <= 7'h00;
                    state_ff  <= ST_CONVERT;
                end
                ST_CONVERT:
                begin
                    // [R15] 111 full periods after first rise
                    if (conv_rise)
                    begin
                        if (cycles_ff == CONV_CYCLES)
                            state_ff <= ST_STORE;
                        else
                            cycles_ff <= cycles_ff + 7'h01;
                    end
                end
                ST_STORE:
                begin
                    // [R18] four conversions per pass, one in single mode
                    slot_ff  <= slot_ff + 2'h1;
                    state_ff <= pass_done ? ST_IDLE : ST_LAUNCH;
                end
            endcase
        end
    end

    // [R10] single mode targets slot zero
    assign done.channel = single_ff ? 3'h0 : {1'b0, slot_ff};
    assign done.data    = I_SAMPLE;

    // [R11] per-channel result storage
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
        begin
            for (int i = 0; i < 4; i++)
                result_ff[i] <= 12'h000;
        end
        else if (state_ff == ST_STORE)
            result_ff[done.channel[1:0]] <= done.data;
    end

    // [R07] flag set by pass end or software, set wins
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
            irq_flag_ff <= 1'b0;
        else if (pass_done || (wr_ctl && I_SFR_WDATA[CTL_IRQ_FLAG]))
            irq_flag_ff <= 1'b1;
        // [R05] clear on write of one
        else if (wr_ctl && I_SFR_WDATA[CTL_IRQ_CLEAR])
            irq_flag_ff <= 1'b0;
    end

    assign ctl_view = {1'b0, refcap_ff, keep_one_ff, irq_flag_ff,
                       irq_en_ff, single_ff, free_run_ff, start_ff};

    // [R22] low eight bits, high four bits
    always_comb
    begin
        nxt_rdata = 8'h00;
        unique case (I_SFR_ADDR)
            OFS_CLOCK_DIVIDER: nxt_rdata = divider_ff;
            OFS_CONTROL:       nxt_rdata = ctl_view;
            OFS_RATE_LOW:      nxt_rdata = rate_ff[7:0];
            OFS_RATE_MID:      nxt_rdata = rate_ff[15:8];
            OFS_RATE_HIGH:     nxt_rdata = rate_ff[23:16];
            OFS_RESULT0_LOW:   nxt_rdata = result_ff[0][7:0];
            OFS_RESULT0_HIGH:  nxt_rdata = {4'h0, result_ff[0][11:8]};
            OFS_RESULT1_LOW:   nxt_rdata = result_ff[1][7:0];
            OFS_RESULT1_HIGH:  nxt_rdata = {4'h0, result_ff[1][11:8]};
            OFS_RESULT2_LOW:   nxt_rdata = result_ff[2][7:0];
            OFS_RESULT2_HIGH:  nxt_rdata = {4'h0, result_ff[2][11:8]};
            OFS_RESULT3_LOW:   nxt_rdata = result_ff[3][7:0];
            OFS_RESULT3_HIGH:  nxt_rdata = {4'h0, result_ff[3][11:8]};
            OFS_INPUT_SEL:     nxt_rdata = input_sel_ff;
            OFS_GAIN_TRIM:     nxt_rdata = gain_trim_ff;
            default:           nxt_rdata = 8'h00;
        endcase
    end

    // registered outputs
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
        begin
            O_SFR_RDATA   <= 8'h00;
            O_MUX_CHANNEL <= 3'h0;
            O_BUFFER_EN   <= 4'h0;
            O_CONV_CLK    <= 1'b0;
            O_CONV_START  <= 1'b0;
            O_BUSY        <= 1'b0;
            O_IRQ_REQ     <= 1'b0;
        end
        else
        begin
            O_SFR_RDATA   <= I_SFR_RD ? nxt_rdata : 8'h00;
            O_MUX_CHANNEL <= nxt_channel;
            O_BUFFER_EN   <= input_sel_ff[3:0];
            O_CONV_CLK    <= conv_clk;
            O_CONV_START  <= (state_ff == ST_LAUNCH);
            O_BUSY        <= (state_ff != ST_IDLE);
            // [R08] local enable gates the request
            // [R19] group and global enables also gate
            O_IRQ_REQ     <= irq_flag_ff && irq_en_ff && I_GROUP_IRQ_EN && I_GLOBAL_IRQ_EN;
        end
    end
endmodule : asq_sequencer

//--- asq_seq_monitor.sv
/*
 port checker for the conversion sequencer.
 assumes mode bits stay still while a pass runs.
*/
`timescale 1ns/1ps
module asq_seq_monitor
    import asq_pkg::*;
(
    input wire logic        I_CORE_CLK,
    input wire logic        I_RST_B,
    input wire logic [7:0]  I_SFR_ADDR,
    input wire logic [7:0]  I_SFR_WDATA,
    input wire logic        I_SFR_WR,
    input wire logic        I_SFR_RD,
    input wire logic [11:0] I_SAMPLE,
    input wire logic        I_GROUP_IRQ_EN,
    input wire logic        I_GLOBAL_IRQ_EN,
    input wire logic [7:0]  O_SFR_RDATA,
    input wire logic [2:0]  O_MUX_CHANNEL,
    input wire logic [3:0]  O_BUFFER_EN,
    input wire logic        O_CONV_CLK,
    input wire logic        O_CONV_START,
    input wire logic        O_BUSY,
    input wire logic        O_IRQ_REQ
);
    logic [7:0]  div_ff, sel_ff;
    logic        ie_ff, one_ff, clk_q_ff, tog;
    logic [9:0]  half_ff;
    logic [1:0]  tog_ff;
    logic [15:0] gap_ff;
    logic        wr_div, wr_sel, wr_ctl;
    assign wr_div = I_SFR_WR && I_SFR_ADDR == OFS_CLOCK_DIVIDER;
    assign wr_sel = I_SFR_WR && I_SFR_ADDR == OFS_INPUT_SEL;
    assign wr_ctl = I_SFR_WR && I_SFR_ADDR == OFS_CONTROL;
    assign tog    = O_CONV_CLK != clk_q_ff;
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_B);
    // shadow of written settings
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
        begin
            div_ff <= RST_DIVIDER;
            sel_ff <= RST_INPUT_SEL;
            ie_ff  <= 1'b0;
            one_ff <= 1'b0;
        end
        else
        begin
            if (wr_div)
                div_ff <= I_SFR_WDATA;
            if (wr_sel)
                sel_ff <= I_SFR_WDATA;
            if (wr_ctl)
                ie_ff <= I_SFR_WDATA[CTL_IRQ_ENABLE];
            if (wr_ctl)
                one_ff <= I_SFR_WDATA[CTL_SINGLE_CHAN];
        end
    end
    // spacing counters
    always_ff @(posedge I_CORE_CLK)
    begin
        clk_q_ff <= O_CONV_CLK;
        half_ff  <= tog ? 10'h001 : half_ff + 10'h001;
        if (!I_RST_B || O_CONV_START)
            gap_ff <= O_CONV_START ? 16'h0001 : 16'hffff;
        else if (gap_ff != 16'hffff)
            gap_ff <= gap_ff + 16'h0001;
        if (wr_div || !O_BUSY)
            tog_ff <= 2'h0;
        else if (tog && tog_ff != 2'h3)
            tog_ff <= tog_ff + 2'h1;
    end
    sequence s_start_write;
        wr_ctl && I_SFR_WDATA[CTL_START] && !I_SFR_WDATA[CTL_FREE_RUN] && !O_BUSY;
    endsequence
    sequence s_launch;
        ##[1:4] O_CONV_START;
    endsequence
    chk_launch_start: assert property (s_start_write |-> s_launch)
        else $error("no start after start write");
    chk_start_pulse: assert property (O_CONV_START |=> !O_CONV_START)
        else $error("start pulse too long");
    chk_conv_span: assert property (O_CONV_START |-> gap_ff >= 16'h01bc)
        else $error("channel conversion cut short");
    chk_clk_half: assert property (tog && tog_ff >= 2'h2 |-> half_ff == ({2'h0, div_ff} + 10'h001) * CLK_HALF_MULT)
        else $error("converter clock half period wrong");
    chk_single_pick: assert property (O_CONV_START && one_ff |-> O_MUX_CHANNEL == sel_ff[6:4])
        else $error("single channel pick wrong");
    chk_bank_pick: assert property (O_CONV_START && !one_ff |-> O_MUX_CHANNEL[2] == sel_ff[SEL_BANK_BIT])
        else $error("bank pick wrong");
    chk_buffer_follow: assert property (wr_sel |=> ##[0:1] O_BUFFER_EN == sel_ff[3:0])
        else $error("buffer enables not updated");
    chk_irq_gate: assert property (O_IRQ_REQ |-> $past(ie_ff) && $past(I_GROUP_IRQ_EN) && $past(I_GLOBAL_IRQ_EN))
        else $error("interrupt request not gated");
    chk_irq_on_end: assert property ($fell(O_BUSY) && ie_ff && I_GROUP_IRQ_EN && I_GLOBAL_IRQ_EN |-> ##[0:3] O_IRQ_REQ)
        else $error("no interrupt after pass");
endmodule : asq_seq_monitor

bind asq_sequencer asq_seq_monitor u_mon (.I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B), .I_SFR_ADDR(I_SFR_ADDR),
    .I_SFR_WDATA(I_SFR_WDATA), .I_SFR_WR(I_SFR_WR), .I_SFR_RD(I_SFR_RD), .I_SAMPLE(I_SAMPLE),
    .I_GROUP_IRQ_EN(I_GROUP_IRQ_EN), .I_GLOBAL_IRQ_EN(I_GLOBAL_IRQ_EN), .O_SFR_RDATA(O_SFR_RDATA),
    .O_MUX_CHANNEL(O_MUX_CHANNEL), .O_BUFFER_EN(O_BUFFER_EN), .O_CONV_CLK(O_CONV_CLK),
    .O_CONV_START(O_CONV_START), .O_BUSY(O_BUSY), .O_IRQ_REQ(O_IRQ_REQ));

//--- asq_core_model.sv
/*
 analog core stand-in: a sample per channel while a pass runs.
 assumes channel and start pulse come together.
*/
`timescale 1ns/1ps
module asq_core_model
    import asq_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_start,
    input  wire logic        i_busy,
    input  wire logic [2:0]  i_channel,
    input  wire logic [11:0] i_base,
    output logic [11:0]      o_sample
);
    logic [2:0]  chan_ff = 3'h0;
    logic [11:0] junk_ff = 12'h000;
    always_ff @(posedge i_clk)
    begin
        if (i_start)
            chan_ff <= i_channel;
        junk_ff <= ~junk_ff ^ 12'h5a3;
    end
    assign o_sample = i_busy ? (i_base ^ {4{chan_ff}}) : junk_ff;
endmodule : asq_core_model

//--- asq_sequencer_test.sv
/*
 self-checking bench for the conversion sequencer.
 assumes the monitor is bound and the core model answers.
*/
`timescale 1ns/1ps
module asq_sequencer_test
    import asq_pkg::*;
;
    logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, grp = 1'b0, glb = 1'b0;
    logic [7:0]  addr = 8'h00, wdat = 8'h00, rdat, cdat;
    logic [11:0] samp, base = 12'h000, es;
    logic [2:0]  mux;
    logic [3:0]  bufen;
    logic        cclk, start, busy, irq;
    logic [31:0] lfsr = 32'h9a6448b7;
    int          err_count = 0, n_compared = 0, n, s;
    time         t0;
    logic [7:0]  ra [4] = '{OFS_CLOCK_DIVIDER, OFS_RATE_LOW, OFS_RATE_MID, OFS_RATE_HIGH};
    logic [2:0]  pk [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic [7:0]  rl [4] = '{OFS_RESULT0_LOW, OFS_RESULT1_LOW, OFS_RESULT2_LOW, OFS_RESULT3_LOW};

    asq_sequencer uut (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_SFR_ADDR(addr), .I_SFR_WDATA(wdat),
        .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SAMPLE(samp), .I_GROUP_IRQ_EN(grp), .I_GLOBAL_IRQ_EN(glb),
        .O_SFR_RDATA(rdat), .O_MUX_CHANNEL(mux), .O_BUFFER_EN(bufen), .O_CONV_CLK(cclk),
        .O_CONV_START(start), .O_BUSY(busy), .O_IRQ_REQ(irq));
    asq_core_model u_core (.i_clk(clk), .i_start(start), .i_busy(busy), .i_channel(mux),
        .i_base(base), .o_sample(samp));

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    function automatic logic [11:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[11:0];
    endfunction : rnd
    function automatic logic [11:0] exp_samp(input logic [11:0] b, input logic [2:0] c);
        return b ^ {4{c}};
    endfunction : exp_samp
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdat = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wreg
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk({8'h00, rdat}, {8'h00, e});
    endtask : rchk
    task automatic wait_idle();
        repeat (6) @(negedge clk);
        n = 0;
        while (busy === 1'b1 && n < 16000)
        begin
            @(negedge clk);
            n++;
        end
        chk(16'(busy), 16'h0000);
    endtask : wait_idle
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    initial
    begin
        #1500000;
        err_count++;
        test_done();
    end

    initial
    begin
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        rchk(OFS_CONTROL, RST_CONTROL);
        rchk(OFS_INPUT_SEL, RST_INPUT_SEL);
        rchk(8'h00, 8'h00);
        rchk(OFS_GAIN_TRIM, RST_GAIN_TRIM);
        wreg(OFS_GAIN_TRIM, 8'hff);
        rchk(OFS_GAIN_TRIM, 8'h80);
        foreach (ra[k])
        begin
            cdat = 8'(rnd());
            rchk(ra[k], RST_RATE_BYTE);
            wreg(ra[k], cdat);
            rchk(ra[k], cdat);
        end
        wreg(OFS_INPUT_SEL, 8'hff);
        rchk(OFS_INPUT_SEL, 8'h7f);
        wreg(OFS_CLOCK_DIVIDER, 8'h00);
        foreach (pk[k])
        begin
            base = rnd();
            wreg(OFS_INPUT_SEL, {1'b0, pk[k], 4'hf});
            wreg(OFS_CONTROL, 8'he5);
            wait_idle();
            es = exp_samp(base, pk[k]);
            rchk(OFS_RESULT0_LOW, es[7:0]);
            rchk(OFS_RESULT0_HIGH, {4'h0, es[11:8]});
            rchk(OFS_CONTROL, 8'h74);
        end
        for (s = 0; s < 2; s++)
        begin
            base = rnd();
            wreg(OFS_INPUT_SEL, {1'b0, s[0], 2'h0, 4'hf});
            wreg(OFS_CONTROL, 8'he1);
            wait_idle();
            foreach (rl[k])
            begin
                es = exp_samp(base, {s[0], k[1:0]});
                rchk(rl[k], es[7:0]);
                rchk(rl[k] + 8'h01, {4'h0, es[11:8]});
            end
        end
        wreg(OFS_CLOCK_DIVIDER, 8'h07);
        wreg(OFS_CONTROL, 8'he0);
        grp = 1'b1;
        glb = 1'b1;
        wreg(OFS_CONTROL, 8'h6d);
        repeat (2) @(posedge cclk);
        t0 = $time;
        @(posedge cclk);
        chk(16'(($time - t0) / 25), 16'h0020);
        wait_idle();
        repeat (3) @(negedge clk);
        chk(16'(irq), 16'h0001);
        glb = 1'b0;
        repeat (2) @(negedge clk);
        chk(16'(irq), 16'h0000);
        glb = 1'b1;
        wreg(OFS_CONTROL, 8'he8);
        repeat (2) @(negedge clk);
        chk(16'(irq), 16'h0000);
        rchk(OFS_CONTROL, 8'h68);
        wreg(OFS_CONTROL, 8'h78);
        repeat (2) @(negedge clk);
        chk(16'(irq), 16'h0001);
        wreg(OFS_CLOCK_DIVIDER, 8'h00);
        wreg(OFS_RATE_LOW, 8'h00);
        wreg(OFS_RATE_MID, 8'h04);
        wreg(OFS_RATE_HIGH, 8'h00);
        wreg(OFS_INPUT_SEL, 8'h2f);
        base = rnd();
        wreg(OFS_CONTROL, 8'he6);
        repeat (2) @(posedge start);
        t0 = $time;
        @(posedge start);
        chk(16'(($time - t0) / 25), 16'h0401);
        es = exp_samp(base, 3'h2);
        rchk(OFS_RESULT0_LOW, es[7:0]);
        wreg(OFS_CONTROL, 8'he0);
        wait_idle();
        n = 0;
        repeat (1200)
        begin
            @(negedge clk);
            if (start === 1'b1)
                n++;
        end
        chk(16'(n), 16'h0000);
        test_done();
    end
endmodule : asq_sequencer_test
